/* include/isd_pkg.sv */
// Purpose: Shared constants and types of the instruction set decoder.
// Assumes: A 14-bit instruction word and an 8-bit data path.
// Notes: The core state is one packed struct registered as a whole.
`default_nettype none
package isd_pkg;
  localparam int unsigned PC_W = 11;
  localparam int unsigned STK_N = 8;
  localparam int unsigned STK_W = 3;
  typedef logic [PC_W-1:0] pc_t;
  localparam pc_t PC_STEP = 11'h001;
  localparam logic [STK_W-1:0] STK_STEP = 3'h1;
  // Instruction classes in the top two bits.
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  // Byte-oriented operation codes.
  localparam logic [3:0] MOVE_TO_FILE_OP = 4'h0;
  localparam logic [3:0] CLEAR_OP = 4'h1;
  localparam logic [3:0] FILE_MINUS_OP = 4'h2;
  localparam logic [3:0] FILE_DEC_OP = 4'h3;
  localparam logic [3:0] FILE_OR_OP = 4'h4;
  localparam logic [3:0] FILE_AND_OP = 4'h5;
  localparam logic [3:0] FILE_XOR_OP = 4'h6;
  localparam logic [3:0] FILE_SUM_OP = 4'h7;
  localparam logic [3:0] FILE_MOVE_OP = 4'h8;
  localparam logic [3:0] FILE_INVERT_OP = 4'h9;
  localparam logic [3:0] FILE_INC_OP = 4'hA;
  localparam logic [3:0] DEC_SKIP_ZERO_OP = 4'hB;
  localparam logic [3:0] ROTATE_DOWN_OP = 4'hC;
  localparam logic [3:0] ROTATE_UP_OP = 4'hD;
  localparam logic [3:0] FILE_SWAP_OP = 4'hE;
  localparam logic [3:0] INC_SKIP_ZERO_OP = 4'hF;
  // Bit-oriented operation codes.
  localparam logic [1:0] BIT_CLEAR_OP = 2'h0;
  localparam logic [1:0] BIT_SET_OP = 2'h1;
  localparam logic [1:0] BIT_TEST_SKIP_LOW_OP = 2'h2;
  localparam logic [1:0] BIT_TEST_SKIP_HIGH_OP = 2'h3;
  // Literal operation codes.
  localparam logic [1:0] IMMEDIATE_MOVE_OP = 2'h0;
  localparam logic [1:0] RETURN_IMMEDIATE_OP = 2'h1;
  localparam logic [3:0] IMMEDIATE_OR_OP = 4'h8;
  localparam logic [3:0] IMMEDIATE_AND_OP = 4'h9;
  localparam logic [3:0] IMMEDIATE_XOR_OP = 4'hA;
  localparam logic [2:0] IMMEDIATE_MINUS_OP = 3'h6;
  localparam logic [2:0] IMMEDIATE_SUM_OP = 3'h7;
  // Fixed control words.
  localparam logic [13:0] CTL_NOP = 14'h0000;
  localparam logic [13:0] CTL_RETURN = 14'h0008;
  localparam logic [13:0] CTL_RETURN_INT = 14'h0009;
  localparam logic [13:0] CTL_STANDBY = 14'h0063;
  localparam logic [13:0] CTL_WDT_CLEAR = 14'h0064;
  // Register bus word indices, taken from byte address bits 3:2.
  localparam logic [1:0] IDX_CTRL = 2'h0;
  localparam logic [1:0] IDX_STATUS = 2'h1;
  localparam logic [1:0] IDX_INSTR = 2'h2;
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_PRESC_TIMER = 1;
  localparam int unsigned CTRL_WAKE = 2;
  localparam int unsigned STS_CARRY = 8;
  localparam int unsigned STS_NIBBLE = 9;
  localparam int unsigned STS_ZERO = 10;
  localparam int unsigned STS_WDT = 11;
  localparam int unsigned STS_PD = 12;
  localparam int unsigned STS_STANDBY = 13;
  localparam int unsigned STS_PC_LSB = 16;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_DECERR = 2'h3;
  typedef enum logic [1:0] {
    ST_HALT = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC = 2'b10,
    ST_STANDBY = 2'b11
  } isd_core_st_t;
  typedef struct packed {
    logic arith_overflow;
    logic nibble_overflow;
    logic null_result;
    logic watchdog_expiry;
    logic power_down;
  } isd_flags_t;
  typedef struct packed {
    isd_core_st_t st;
    pc_t pc;
    logic [13:0] instr;
    logic nop;
    logic [7:0] acc;
    isd_flags_t flg;
    logic [STK_N-1:0][PC_W-1:0] stk;
    logic [STK_W-1:0] sp;
    logic [6:0] rf_addr;
    logic [7:0] rf_wdata;
    logic rf_we;
    logic presc_clr;
    logic [7:0] pin1;
    logic [7:0] pin2;
    logic run;
    logic presc_sel;
    logic awrdy;
    logic wrdy;
    logic awgot;
    logic wgot;
    logic [1:0] awidx;
    logic [2:0] wbits;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } isd_state_t;
endpackage
`default_nettype wire

/* src/isd_core.sv */
// Purpose: Fetches, decodes and executes 14-bit instruction words.
// Assumes: Program memory and data file answer combinationally.
// Notes: One instruction cycle is a fetch clock and an execute clock.
`timescale 1ns/1ps
`default_nettype none
module isd_core
  import isd_pkg::*;
#(
  parameter logic [6:0] PORT_ADDR = 7'h06,
  parameter logic [6:0] TIMER_ADDR = 7'h01
) (
  input wire logic aclk, // Core clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic ce, // Clock enable, freezes all state.
  output logic [PC_W-1:0] pm_addr_o, // Program memory address.
  input wire logic [13:0] pm_data_i, // Instruction word at that address.
  output logic [6:0] rf_addr_o, // Data file address.
  input wire logic [7:0] rf_rdata_i, // Data file read value.
  output logic [7:0] rf_wdata_o, // Data file write value.
  output logic rf_we_o, // Data file write pulse.
  input wire logic [7:0] pins_i, // Port pin levels, asynchronous.
  output logic presc_clr_o, // Prescaler clear pulse.
  input wire logic [3:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [3:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready // Read data ready.
);
  isd_state_t s_q;
  isd_state_t s_d;
  localparam isd_state_t RESET_ST = '0;

  // Working values of the execute step and of the bus slave.
  logic [13:0] ins;
  logic [7:0] src;
  logic [7:0] opnd;
  logic [7:0] res;
  logic [8:0] sum_add;
  logic [8:0] sum_sub;
  logic [4:0] nib_add;
  logic [4:0] nib_sub;
  logic to_file;
  logic to_acc;
  logic set_z;
  logic skip;
  logic jump;
  logic [STK_W-1:0] sp_dn;
  logic [31:0] rd;
  logic wake;

  // Next state: bus slave first, then the core sequencer.
  always_comb begin
    s_d = s_q;
    s_d.rf_we = 1'b0;
    s_d.presc_clr = 1'b0;
    ins = s_q.instr;
    res = 8'h00;
    to_file = 1'b0;
    to_acc = 1'b0;
    set_z = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    wake = 1'b0;
    rd = 32'h0000_0000;
    sp_dn = s_q.sp - STK_STEP;
    // The first stage feeds only the second one.
    s_d.pin1 = pins_i;
    s_d.pin2 = s_q.pin1;
    src = (s_q.rf_addr == PORT_ADDR) ? s_q.pin2 : rf_rdata_i;
    opnd = (ins[13:12] == CLS_LIT) ? ins[7:0] : src;
    sum_add = {1'b0, opnd} + {1'b0, s_q.acc};
    sum_sub = {1'b0, opnd} + {1'b0, ~s_q.acc} + 9'h001;
    nib_add = {1'b0, opnd[3:0]} + {1'b0, s_q.acc[3:0]};
    nib_sub = {1'b0, opnd[3:0]} + {1'b0, ~s_q.acc[3:0]} + 5'h01;

    // Write channel: address and data are taken in either order.
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_q.awrdy) begin
      s_d.awgot = 1'b1;
      s_d.awidx = s_axi_awaddr[3:2];
    end
    if (s_axi_wvalid && s_q.wrdy) begin
      s_d.wgot = 1'b1;
      s_d.wbits = s_axi_wdata[2:0];
      s_d.wstrb0 = s_axi_wstrb[0];
    end
    if (s_d.awgot && s_d.wgot && !s_q.bvalid) begin
      s_d.awgot = 1'b0;
      s_d.wgot = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = AXI_OKAY;
      if (s_d.awidx == IDX_CTRL) begin
        if (s_d.wstrb0) begin
          s_d.run = s_d.wbits[CTRL_RUN];
          s_d.presc_sel = s_d.wbits[CTRL_PRESC_TIMER];
          wake = s_d.wbits[CTRL_WAKE];
        end
      end else if (s_d.awidx != IDX_STATUS && s_d.awidx != IDX_INSTR) begin
        s_d.bresp = AXI_DECERR;
      end
    end
    // Read channel: one read in flight, answered the next cycle.
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arrdy) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = AXI_OKAY;
      case (s_axi_araddr[3:2])
        IDX_CTRL: begin
          rd[CTRL_RUN] = s_q.run;
          rd[CTRL_PRESC_TIMER] = s_q.presc_sel;
        end
        IDX_STATUS: begin
          rd[7:0] = s_q.acc;
          rd[STS_CARRY] = s_q.flg.arith_overflow;
          rd[STS_NIBBLE] = s_q.flg.nibble_overflow;
          rd[STS_ZERO] = s_q.flg.null_result;
          rd[STS_WDT] = s_q.flg.watchdog_expiry;
          rd[STS_PD] = s_q.flg.power_down;
          rd[STS_STANDBY] = (s_q.st == ST_STANDBY);
          rd[STS_PC_LSB +: PC_W] = s_q.pc;
        end
        IDX_INSTR: begin
          rd[13:0] = s_q.instr;
        end
        default: begin
          s_d.rresp = AXI_DECERR;
        end
      endcase
      s_d.rdata = rd;
    end

    // Core sequencer.
    case (s_q.st)
      ST_HALT: begin
        if (s_q.run) begin
          s_d.st = ST_FETCH;
        end
      end
      ST_FETCH: begin
        s_d.st = ST_EXEC;
        if (s_q.nop) begin
          s_d.nop = 1'b0;
          s_d.instr = CTL_NOP;
        end else begin
          s_d.instr = pm_data_i;
          s_d.rf_addr = pm_data_i[6:0];
          s_d.pc = s_q.pc + PC_STEP;
        end
      end
      ST_EXEC: begin
        s_d.st = s_q.run ? ST_FETCH : ST_HALT;
        case (ins[13:12])
          CLS_BYTE: begin
            if (ins[11:7] == 5'h00) begin
              if (ins == CTL_RETURN || ins == CTL_RETURN_INT) begin
                s_d.sp = sp_dn;
                s_d.pc = s_q.stk[sp_dn];
                jump = 1'b1;
              end else if (ins == CTL_WDT_CLEAR) begin
                s_d.flg.watchdog_expiry = 1'b1;
                s_d.flg.power_down = 1'b1;
              end else if (ins == CTL_STANDBY) begin
                s_d.flg.watchdog_expiry = 1'b1;
                s_d.flg.power_down = 1'b0;
                s_d.st = ST_STANDBY;
              end
            end else begin
              to_file = ins[7];
              to_acc = !ins[7];
              case (ins[11:8])
                MOVE_TO_FILE_OP: res = s_q.acc;
                CLEAR_OP: begin
                  res = 8'h00;
                  set_z = 1'b1;
                end
                FILE_MINUS_OP: begin
                  res = sum_sub[7:0];
                  s_d.flg.arith_overflow = sum_sub[8];
                  s_d.flg.nibble_overflow = nib_sub[4];
                  set_z = 1'b1;
                end
                FILE_DEC_OP: begin
                  res = src - 8'h01;
                  set_z = 1'b1;
                end
                FILE_OR_OP: begin
                  res = src | s_q.acc;
                  set_z = 1'b1;
                end
                FILE_AND_OP: begin
                  res = src & s_q.acc;
                  set_z = 1'b1;
                end
                FILE_XOR_OP: begin
                  res = src ^ s_q.acc;
                  set_z = 1'b1;
                end
                FILE_SUM_OP: begin
                  res = sum_add[7:0];
                  s_d.flg.arith_overflow = sum_add[8];
                  s_d.flg.nibble_overflow = nib_add[4];
                  set_z = 1'b1;
                end
                FILE_MOVE_OP: begin
                  res = src;
                  set_z = 1'b1;
                end
                FILE_INVERT_OP: begin
                  res = ~src;
                  set_z = 1'b1;
                end
                FILE_INC_OP: begin
                  res = src + 8'h01;
                  set_z = 1'b1;
                end
                DEC_SKIP_ZERO_OP: begin
                  res = src - 8'h01;
                  skip = (res == 8'h00);
                end
                ROTATE_DOWN_OP: begin
                  res = {s_q.flg.arith_overflow, src[7:1]};
                  s_d.flg.arith_overflow = src[0];
                end
                ROTATE_UP_OP: begin
                  res = {src[6:0], s_q.flg.arith_overflow};
                  s_d.flg.arith_overflow = src[7];
                end
                FILE_SWAP_OP: res = {src[3:0], src[7:4]};
                INC_SKIP_ZERO_OP: begin
                  res = src + 8'h01;
                  skip = (res == 8'h00);
                end
                default: res = src;
              endcase
            end
          end
          CLS_BIT: begin
            res = src;
            case (ins[11:10])
              BIT_CLEAR_OP: begin
                res[ins[9:7]] = 1'b0;
                to_file = 1'b1;
              end
              BIT_SET_OP: begin
                res[ins[9:7]] = 1'b1;
                to_file = 1'b1;
              end
              BIT_TEST_SKIP_LOW_OP: skip = !src[ins[9:7]];
              BIT_TEST_SKIP_HIGH_OP: skip = src[ins[9:7]];
              default: skip = 1'b0;
            endcase
          end
          CLS_JUMP: begin
            if (!ins[11]) begin
              s_d.stk[s_q.sp] = s_q.pc;
              s_d.sp = s_q.sp + STK_STEP;
            end
            s_d.pc = ins[10:0];
            jump = 1'b1;
          end
          CLS_LIT: begin
            if (ins[11:10] == IMMEDIATE_MOVE_OP) begin
              s_d.acc = ins[7:0];
            end else if (ins[11:10] == RETURN_IMMEDIATE_OP) begin
              s_d.acc = ins[7:0];
              s_d.sp = sp_dn;
              s_d.pc = s_q.stk[sp_dn];
              jump = 1'b1;
            end else if (ins[11:9] == IMMEDIATE_SUM_OP) begin
              res = sum_add[7:0];
              s_d.flg.arith_overflow = sum_add[8];
              s_d.flg.nibble_overflow = nib_add[4];
              set_z = 1'b1;
              to_acc = 1'b1;
            end else if (ins[11:9] == IMMEDIATE_MINUS_OP) begin
              res = sum_sub[7:0];
              s_d.flg.arith_overflow = sum_sub[8];
              s_d.flg.nibble_overflow = nib_sub[4];
              set_z = 1'b1;
              to_acc = 1'b1;
            end else begin
              case (ins[11:8])
                IMMEDIATE_OR_OP: res = ins[7:0] | s_q.acc;
                IMMEDIATE_AND_OP: res = ins[7:0] & s_q.acc;
                IMMEDIATE_XOR_OP: res = ins[7:0] ^ s_q.acc;
                default: res = s_q.acc;
              endcase
              set_z = 1'b1;
              to_acc = 1'b1;
            end
          end
          default: res = 8'h00;
        endcase
        if (set_z) begin
          s_d.flg.null_result = (res == 8'h00);
        end
        if (to_acc) begin
          s_d.acc = res;
        end
        if (to_file) begin
          s_d.rf_we = 1'b1;
          s_d.rf_wdata = res;
          if (s_q.rf_addr == TIMER_ADDR && s_q.presc_sel) begin
            s_d.presc_clr = 1'b1;
          end
        end
        if (skip) begin
          s_d.pc = s_q.pc + PC_STEP;
        end
        s_d.nop = skip || jump;
      end
      ST_STANDBY: begin
        // Only a wake write brings the core back; no clock is stopped.
        s_d.st = ST_STANDBY;
      end
      default: s_d.st = ST_HALT;
    endcase

    // A wake write is seen as it commits, since both halves clear then.
    if (wake && s_q.st == ST_STANDBY) begin
      s_d.st = ST_HALT;
    end
    s_d.awrdy = !s_d.awgot && !s_d.bvalid;
    s_d.wrdy = !s_d.wgot && !s_d.bvalid;
    s_d.arrdy = !s_d.rvalid;
  end

  // All state moves together and holds while the enable is low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= RESET_ST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Every output is a field of the registered state.
  assign pm_addr_o = s_q.pc;
  assign rf_addr_o = s_q.rf_addr;
  assign rf_wdata_o = s_q.rf_wdata;
  assign rf_we_o = s_q.rf_we;
  assign presc_clr_o = s_q.presc_clr;
  assign s_axi_awready = s_q.awrdy;
  assign s_axi_wready = s_q.wrdy;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_arready = s_q.arrdy;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rvalid = s_q.rvalid;
endmodule
`default_nettype wire

/* test/isd_core_asserts.sv */
// Purpose: Port checks on the decoder core and its register bus.
// Assumes: One clock; checks pause while reset or clock enable is low.
// Notes: Bound to every isd_core instance at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module isd_core_asserts
  import isd_pkg::*;
#(
  parameter logic [6:0] TIMER_ADDR = 7'h01
) (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset, low.
  input wire logic ce, // Enable.
  input wire logic s_axi_awvalid, // Aw valid.
  input wire logic s_axi_awready, // Aw ready.
  input wire logic s_axi_wvalid, // W valid.
  input wire logic s_axi_wready, // W ready.
  input wire logic [1:0] s_axi_bresp, // B code.
  input wire logic s_axi_bvalid, // B valid.
  input wire logic s_axi_bready, // B ready.
  input wire logic [3:0] s_axi_araddr, // Ar address.
  input wire logic s_axi_arvalid, // Ar valid.
  input wire logic s_axi_arready, // Ar ready.
  input wire logic [31:0] s_axi_rdata, // R data.
  input wire logic [1:0] s_axi_rresp, // R code.
  input wire logic s_axi_rvalid, // R valid.
  input wire logic s_axi_rready, // R ready.
  input wire logic [6:0] rf_addr_o, // File address.
  input wire logic rf_we_o, // File write.
  input wire logic presc_clr_o // Prescaler clear.
);
  // A frozen core makes every timing relation meaningless, so pause then.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !ce);

  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read data late");
  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  a_data_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("r dropped");
  a_decode_error: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[3:2] == 2'h3 |=> s_axi_rresp == AXI_DECERR)
    else $error("hole not refused");
  a_busy_refuse: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
  a_write_pulse:
    assert property (rf_we_o |=> !rf_we_o) else $error("write too long");
  a_timer_clear:
    assert property (presc_clr_o |-> rf_we_o && rf_addr_o == TIMER_ADDR)
    else $error("stray prescaler clear");
  a_clear_pulse:
    assert property (presc_clr_o |=> !presc_clr_o) else $error("clear long");
endmodule
bind isd_core isd_core_asserts #(.TIMER_ADDR(TIMER_ADDR)) u_chk (
  .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .rf_addr_o, .rf_we_o, .presc_clr_o);
`default_nettype wire

/* test/isd_mem_model.sv */
// Purpose: Program memory and data file seen by the decoder core.
// Assumes: Both read combinationally; the file writes on the pulse edge.
// Notes: The bench loads words and cells directly before reset ends.
`timescale 1ns/1ps
`default_nettype none
module isd_mem_model
  import isd_pkg::*;
(
  input wire logic aclk, // Clock.
  input wire logic [PC_W-1:0] pm_addr, // Fetch address.
  output logic [13:0] pm_data, // Fetched word.
  input wire logic [6:0] rf_addr, // File address.
  input wire logic [7:0] rf_wdata, // Write value.
  input wire logic rf_we, // Write pulse.
  output logic [7:0] rf_rdata // Read value.
);
  logic [13:0] words [0:31];
  logic [7:0] cells [0:127];
  // Only 32 words are stored; fetches beyond them see no-operations.
  assign pm_data = (pm_addr < 11'h020) ? words[pm_addr[4:0]] : CTL_NOP;
  assign rf_rdata = cells[rf_addr];
  // The write lands at the edge where the pulse is seen.
  always @(posedge aclk) begin
    if (rf_we) begin
      cells[rf_addr] <= rf_wdata;
    end
  end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Purpose: Runs a short program on the core and checks its results.
// Assumes: Register bus tasks follow the AXI4-Lite handshakes.
// Notes: Skipped words load 8'hEE, which would spoil later results.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import isd_pkg::*;
  localparam logic [13:0] PROG [23] = '{14'h300F, 14'h04A0, 14'h0520,
    14'h0620, 14'h3801, 14'h3AF1, 14'h390F, 14'h0BA1, 14'h30EE, 14'h3C00,
    14'h0DA2, 14'h0FA3, 14'h30EE, 14'h1820, 14'h1FA0, 14'h30EE, 14'h0081,
    14'h0486, 14'h2016, 14'h0063, 14'h30EE, 14'h0000, 14'h3477};
  localparam logic [6:0] FA [6] = '{7'h20, 7'h21, 7'h22, 7'h23, 7'h06, 7'h01};
  localparam logic [7:0] FI [6] = '{8'hF0, 8'h01, 8'h80, 8'hFF, 8'hA5, 8'h33};
  localparam logic [7:0] FV [6] = '{8'hFF, 8'h00, 8'h01, 8'h00, 8'h5A, 8'h00};
  logic aclk, aresetn, ce, rf_we_o, presc_clr_o;
  logic [PC_W-1:0] pm_addr_o;
  logic [13:0] pm_data_i;
  logic [6:0] rf_addr_o;
  logic [7:0] rf_rdata_i, rf_wdata_o, pins_i;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int n_errors = 0;
  int n_checks = 0;
  int n_presc = 0;
  int cycles = 0;

  isd_core uut (.aclk, .aresetn, .ce, .pm_addr_o, .pm_data_i, .rf_addr_o,
    .rf_rdata_i, .rf_wdata_o, .rf_we_o, .pins_i, .presc_clr_o, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  isd_mem_model mem (.aclk, .pm_addr(pm_addr_o), .pm_data(pm_data_i),
    .rf_addr(rf_addr_o), .rf_wdata(rf_wdata_o), .rf_we(rf_we_o),
    .rf_rdata(rf_rdata_i));

  // Free running clock at 200 MHz.
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Counts prescaler clears and cuts a hang short.
  always @(posedge aclk) begin
    cycles++;
    if (presc_clr_o === 1'b1) n_presc++;
    if (cycles == 5000) begin
      n_errors++;
      $display("unexpected at %0t: run timed out", $time);
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Address and data are offered together and each drops when taken.
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Ready stands with the request; data are taken where valid shows.
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Main sequence: bus checks, program run, results, wake.
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    d = '0;
    aresetn = 1'b0;
    ce = 1'b1;
    pins_i = 8'h5A;
    s_axi_awaddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    s_axi_araddr = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    for (int i = 0; i < 32; i++) mem.words[i] = (i < 23) ? PROG[i] : CTL_NOP;
    for (int i = 0; i < 128; i++) mem.cells[i] = 8'h00;
    for (int i = 0; i < 6; i++) mem.cells[FA[i]] = FI[i];
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(4'h0, 32'h0000_0006, r);
    chk(32'(r), 32'(AXI_OKAY));
    rd(4'h0, d, r);
    chk(d, 32'h0000_0002);
    wr(4'hC, 32'h0000_0001, r);
    chk(32'(r), 32'(AXI_DECERR));
    rd(4'hC, d, r);
    chk(32'(r), 32'(AXI_DECERR));
    wr(4'h4, 32'hFFFF_FFFF, r);
    chk(32'(r), 32'(AXI_OKAY));
    wr(4'h0, 32'h0000_0003, r);
    // A low enable must hold the program counter where it stands.
    ce <= 1'b0;
    @(posedge aclk);
    d = 32'(pm_addr_o);
    repeat (2) @(posedge aclk);
    chk(32'(pm_addr_o), d);
    ce <= 1'b1;
    for (int i = 0; i < 100 && d[STS_STANDBY] !== 1'b1; i++) rd(4'h4, d, r);
    chk(32'(d[7:0]), 32'h0000_0077);
    chk(32'(d[13:8]), 32'h0000_002B);
    for (int i = 0; i < 6; i++) begin
      chk(32'(mem.cells[FA[i]]), 32'(FV[i]));
    end
    chk(32'(n_presc), 32'h0000_0001);
    rd(4'h8, d, r);
    chk(32'(d[13:0]), 32'(CTL_STANDBY));
    wr(4'h0, 32'h0000_0004, r);
    rd(4'h4, d, r);
    chk(32'(d[STS_STANDBY]), 32'h0000_0000);
    rd(4'h0, d, r);
    chk(d, 32'h0000_0000);
    wrap_up();
  end
endmodule
`default_nettype wire
